// ### core/odtmt_pkg.sv
// constants, register map and types of the termination mode logic
package odtmt_pkg;
  // clock period and derived timing
  localparam int CLK_PERIOD_PS = 50000;
  localparam int LAT_OFFSET = 2;
  localparam int ANPD_OFFSET = 1;
  localparam int CHOP_EXTRA = 4;
  localparam int FULL_EXTRA = 6;
  localparam int HOLD_SHORT = 4;
  localparam int HOLD_LONG = 6;
  localparam int WL_MIN = 5;
  // register map
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int CFG_WL_LSB = 0;
  localparam int CFG_WL_W = 5;
  localparam int CFG_RTT_WR_LSB = 5;
  localparam int CFG_PD_DLL_BIT = 7;
  localparam int CFG_CHOP_BIT = 8;
  localparam int CFG_OTF_BIT = 9;
  localparam int ST_RTT_ON_BIT = 0;
  localparam int ST_RTT_WR_BIT = 1;
  localparam int ST_ASYNC_BIT = 2;
  localparam int ST_WINDOW_BIT = 3;
  localparam int ST_PD_BIT = 4;
  localparam logic [4:0] WL_RESET = 5'h05;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic otf_en;
    logic fixed_chop;
    logic pd_dll_fast;
    logic [1:0] rtt_wr_sel;
    logic [CFG_WL_W-1:0] wl;
  } odtmt_cfg_s;

  typedef struct packed {
    logic odt;
    logic cke;
    logic wr_cmd;
    logic wr_chop;
    logic ref_cmd;
  } odtmt_pins_s;

  typedef struct packed {
    logic rtt_on;
    logic rtt_wr_sel;
    logic async_mode;
    logic window;
    logic power_down;
  } odtmt_term_s;

  typedef enum logic [1:0] {
    ODTMT_SYNC,
    ODTMT_ENTRY,
    ODTMT_ASYNC,
    ODTMT_EXIT
  } odtmt_mode_e;
endpackage

// ### core/odtmt_core.sv
// termination mode logic: synchronous, dynamic and power-down asynchronous
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module odtmt_core #(
  parameter int HIST_DEPTH = 32,      // longest write latency served, capped at 31 by the field
  parameter int ENTRY_CYC = 1,        // powerdown_entry_delay in clocks
  parameter int EXIT_DLL_CYC = 10,    // powerdown_exit_dll_delay in clocks
  parameter int REFRESH_NS = 160      // minimum refresh cycle time
) (
  input wire logic hclk,                 // clock
  input wire logic hresetn,              // async reset, active low
  input wire logic ce,                   // clock enable
  input wire logic hsel,                 // slave select
  input wire logic [7:0] haddr,          // byte address
  input wire logic [1:0] htrans,         // transfer type
  input wire logic hwrite,               // write when high
  input wire logic [2:0] hsize,          // transfer size
  input wire logic hready,               // bus ready
  input wire logic [31:0] hwdata,        // write data
  output logic [31:0] hrdata,            // read data
  output logic hreadyout,                // slave ready
  output logic hresp,                    // response, always okay
  input wire odtmt_pkg::odtmt_pins_s pins, // registered pin inputs
  output odtmt_pkg::odtmt_term_s term    // termination state
);
  import odtmt_pkg::*;

  localparam int REFRESH_CYC_RAW =
    (REFRESH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYC = REFRESH_CYC_RAW < 1 ? 1 : REFRESH_CYC_RAW;
  localparam int CNT_W = 12;
  // clamp to what both the field and the history can serve
  localparam int WL_FIELD_MAX = (1 << CFG_WL_W) - 1;
  localparam int WL_MAX = HIST_DEPTH > WL_FIELD_MAX ? WL_FIELD_MAX : HIST_DEPTH;

  if (HIST_DEPTH < 8 || HIST_DEPTH > 32 || ENTRY_CYC < 1 ||
      EXIT_DLL_CYC < 1 || REFRESH_CYC >= (1 << CNT_W) ||
      ENTRY_CYC >= (1 << CNT_W) || EXIT_DLL_CYC >= (1 << CNT_W))
  begin : gen_param_check
    $error("odtmt_core: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  odtmt_cfg_s cfg_reg;
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  wire logic addr_phase = hsel && htrans == HTRANS_NONSEQ && hready && ce;
  wire logic cfg_hit = addr_reg == CFG_OFFSET;
  wire logic cfg_rd = haddr == CFG_OFFSET;
  wire logic st_rd = haddr == STATUS_OFFSET;
  wire logic [31:0] status_word = {27'h0000000, term.power_down, term.window,
    term.async_mode, term.rtt_wr_sel, term.rtt_on};
  wire logic [31:0] read_mux = cfg_rd ? {22'h000000, cfg_reg} :
    st_rd ? status_word : 32'h00000000;

  assign hreadyout = ce;  // a frozen block stalls the bus
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase)
        addr_reg <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg <= '{otf_en: 1'b0, fixed_chop: 1'b0, pd_dll_fast: 1'b0,
        rtt_wr_sel: 2'h0, wl: WL_RESET};
      hrdata <= 32'h00000000;
    end
    else if (ce)
    begin
      if (wr_pend_reg && cfg_hit)
        cfg_reg <= hwdata[$bits(odtmt_cfg_s)-1:0];
      // read data launched in the address phase, stands for the data phase
      if (addr_phase && !hwrite)
        hrdata <= read_mux;
      else if (!rd_pend_reg)
        hrdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latencies
  wire logic [CFG_WL_W-1:0] wl_eff =
    (cfg_reg.wl < CFG_WL_W'(WL_MIN)) ? CFG_WL_W'(WL_MIN) :
    (int'(cfg_reg.wl) > WL_MAX) ? CFG_WL_W'(WL_MAX) : cfg_reg.wl;
  wire logic [CFG_WL_W-1:0] odt_lat = wl_eff - CFG_WL_W'(LAT_OFFSET);
  wire logic [CNT_W-1:0] lat_ext = CNT_W'(odt_lat);
  wire logic dyn_en = |cfg_reg.rtt_wr_sel;
  wire logic chop_eff = cfg_reg.otf_en ? pins.wr_chop : cfg_reg.fixed_chop;
  // unused lane is ignored; only whole words are served
  wire logic [2:0] unused_size = hsize;

  ////////////////////////////////////////////////////////////////////////////
  // synchronous path: registered ODT history
  logic [HIST_DEPTH-1:0] hist_reg;
  wire logic sync_odt = hist_reg[odt_lat - 1'b1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hist_reg <= '0;
    else if (ce)
      hist_reg <= {hist_reg[HIST_DEPTH-2:0], pins.odt};
  end

  ////////////////////////////////////////////////////////////////////////////
  // dynamic termination strength
  logic [CNT_W-1:0] wr_cnt_reg;
  logic wr_chop_reg;
  logic rtt_wr_reg;
  wire logic [CNT_W-1:0] wr_end = lat_ext +
    (wr_chop_reg ? CNT_W'(CHOP_EXTRA) : CNT_W'(FULL_EXTRA));
  wire logic wr_running = wr_cnt_reg != '0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_cnt_reg <= '0;
      wr_chop_reg <= 1'b0;
      rtt_wr_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!dyn_en)
      begin
        wr_cnt_reg <= '0;
        rtt_wr_reg <= 1'b0;
      end
      else if (pins.wr_cmd)
      begin
        // a new write restarts the sequence; the controller spaces writes
        wr_cnt_reg <= CNT_W'(1);
        wr_chop_reg <= chop_eff;
      end
      else if (wr_running)
      begin
        if (wr_cnt_reg == lat_ext)
          rtt_wr_reg <= 1'b1;
        if (wr_cnt_reg == wr_end)
        begin
          rtt_wr_reg <= 1'b0;
          wr_cnt_reg <= '0;
        end
        else
          wr_cnt_reg <= wr_cnt_reg + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh cycle tracking
  logic [CNT_W-1:0] rfc_cnt_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rfc_cnt_reg <= '0;
    else if (ce)
    begin
      if (pins.ref_cmd)
        rfc_cnt_reg <= CNT_W'(REFRESH_CYC);
      else if (rfc_cnt_reg != '0)
        rfc_cnt_reg <= rfc_cnt_reg - CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down mode control
  odtmt_mode_e mode_reg;
  logic pd_reg;
  logic [CNT_W-1:0] win_cnt_reg;
  logic rtt_on_reg;
  wire logic pd_enter = !pd_reg && !pins.cke;
  wire logic pd_leave = pd_reg && pins.cke;
  // remaining refresh time counted from this same edge
  wire logic [CNT_W-1:0] rfc_left =
    (rfc_cnt_reg > CNT_W'(1)) ? rfc_cnt_reg - CNT_W'(1) : '0;
  wire logic [CNT_W-1:0] entry_load =
    (rfc_left > CNT_W'(ENTRY_CYC)) ? rfc_left : CNT_W'(ENTRY_CYC);
  wire logic async_path = mode_reg == ODTMT_ASYNC;
  wire logic win_last = win_cnt_reg == CNT_W'(1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg <= ODTMT_SYNC;
      pd_reg <= 1'b0;
      win_cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (pd_enter)
        pd_reg <= 1'b1;
      else if (pd_leave)
        pd_reg <= 1'b0;
      unique case (mode_reg)
        ODTMT_SYNC:
          // the lead part before CKE low is still answered by the clocked
          // pipeline, which is one of the two permitted responses
          if (pd_enter && !cfg_reg.pd_dll_fast)
          begin
            mode_reg <= ODTMT_ENTRY;
            win_cnt_reg <= entry_load;
          end
        ODTMT_ENTRY:
          if (win_last)  // end clock included
          begin
            win_cnt_reg <= '0;
            mode_reg <= pd_reg && !pd_leave ? ODTMT_ASYNC : ODTMT_SYNC;
          end
          else
            win_cnt_reg <= win_cnt_reg - CNT_W'(1);
        ODTMT_ASYNC:
          if (pd_leave)
          begin
            mode_reg <= ODTMT_EXIT;
            win_cnt_reg <= CNT_W'(EXIT_DLL_CYC);
          end
        ODTMT_EXIT:
          if (win_last)
          begin
            win_cnt_reg <= '0;
            mode_reg <= ODTMT_SYNC;
          end
          else
            win_cnt_reg <= win_cnt_reg - CNT_W'(1);
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination output
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rtt_on_reg <= 1'b0;
    else if (ce)
      // receiver stays live in power-down; no latency when frozen
      rtt_on_reg <= async_path ? pins.odt : sync_odt;
  end

  wire logic window_on = mode_reg == ODTMT_ENTRY || mode_reg == ODTMT_EXIT;

  assign term = '{rtt_on: rtt_on_reg, rtt_wr_sel: rtt_wr_reg,
    async_mode: async_path, window: window_on, power_down: pd_reg};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wire logic wl5 = wl_eff == CFG_WL_W'(WL_MIN);
  wire logic sync_hold = mode_reg == ODTMT_SYNC;

  sync_turn_on_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (sync_hold && wl5 && pins.odt && !hist_reg[0]) ##1
      (sync_hold && wl5)[*3] |=> term.rtt_on)
    else $error("termination not on at turn-on latency after ODT high");

  sync_turn_off_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (sync_hold && wl5 && !pins.odt && hist_reg[0]) ##1
      (sync_hold && wl5)[*3] |=> !term.rtt_on)
    else $error("termination not off at turn-off latency after ODT low");

  dyn_gate_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    !dyn_en |=> !term.rtt_wr_sel)
    else $error("write strength selected with dynamic mode off");

  wr_select_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (dyn_en && wl5 && pins.wr_cmd) ##1 (!pins.wr_cmd && dyn_en)[*3]
      |-> !term.rtt_wr_sel ##1 term.rtt_wr_sel)
    else $error("write strength not selected at turn-on latency");

  chop_release_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (dyn_en && wl5 && pins.wr_cmd && chop_eff) ##1
      (!pins.wr_cmd && dyn_en)[*7] |-> term.rtt_wr_sel ##1 !term.rtt_wr_sel)
    else $error("chopped write strength not released at latency plus 4");

  full_release_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (dyn_en && wl5 && pins.wr_cmd && !chop_eff) ##1
      (!pins.wr_cmd && dyn_en)[*8] |=> term.rtt_wr_sel ##1 !term.rtt_wr_sel)
    else $error("full write strength not released at latency plus 6");

  async_entry_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    term.async_mode |-> pd_reg && !cfg_reg.pd_dll_fast)
    else $error("asynchronous mode outside frozen-DLL power-down");

  async_follow_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    term.async_mode |=> term.rtt_on == $past(pins.odt))
    else $error("asynchronous termination does not follow ODT directly");

  no_window_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (sync_hold && cfg_reg.pd_dll_fast) |=> !term.window)
    else $error("transition window with DLL kept on");

  entry_end_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (sync_hold && pd_enter && !cfg_reg.pd_dll_fast && rfc_cnt_reg == '0
      && ENTRY_CYC == 1) ##1 !pd_leave |=> !term.window && term.async_mode)
    else $error("entry window not closed after entry delay");

  exit_start_a: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (term.async_mode && pins.cke) |=> term.window && !term.async_mode)
    else $error("exit window did not open when CKE registered high");
endmodule // odtmt_core

`default_nettype wire

// ### sim/odtmt_ctrl_model.sv
// controller-side model that drives odt, cke and command strobes
`timescale 1ns/1ps
`default_nettype none
module odtmt_ctrl_model (
  input wire logic hclk,              // clock
  input wire logic hresetn,           // async reset, active low
  input wire logic odt_req,           // wanted odt level
  input wire logic cke_req,           // wanted cke level
  input wire logic wr_req,            // issue a write
  input wire logic chop_req,          // write is a chopped burst
  input wire logic ref_req,           // issue a refresh
  output var odtmt_pkg::odtmt_pins_s pins // registered pin levels
);
  import odtmt_pkg::*;
  logic [2:0] hold_reg;
  logic [2:0] hold_next;
  logic wr_go;
  // no write while cke is low or dropping
  assign wr_go = wr_req && cke_req && pins.cke;
  // odt kept high 6 or 4 clocks after a write, 4 after a rise
  assign hold_next = wr_go ? (chop_req ? 3'(HOLD_SHORT) : 3'(HOLD_LONG)) :
    (odt_req && !pins.odt) ? 3'(HOLD_SHORT) :
    (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_reg <= 3'h0;
      pins <= 5'h08;
    end
    else
    begin
      hold_reg <= hold_next;
      pins.odt <= odt_req || (hold_next != 3'h0);
      pins.cke <= cke_req;
      pins.wr_cmd <= wr_go;
      pins.wr_chop <= chop_req;
      // no refresh in power-down either
      pins.ref_cmd <= ref_req && cke_req && pins.cke;
    end
  end
endmodule // odtmt_ctrl_model
`default_nettype wire

// ### sim/odt_mode_transition_logic_tb.sv
// self-checking bench of the termination mode logic
`timescale 1ns/1ps
`default_nettype none
module odt_mode_transition_logic_tb;
  import odtmt_pkg::*;
  localparam int EXIT_CYC = 6;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic odt_req = 1'b0;
  logic cke_req = 1'b1;
  logic wr_req = 1'b0;
  logic chop_req = 1'b0;
  logic ref_req = 1'b0;
  odtmt_pins_s pins;
  odtmt_term_s term;
  int errors = 0;
  int check_count = 0;
  logic [31:0] lfsr_reg = 32'h24E1;

  odtmt_core #(.HIST_DEPTH(32), .ENTRY_CYC(1), .EXIT_DLL_CYC(EXIT_CYC),
    .REFRESH_NS(160)) u_odtmt_core (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .term(term));
  odtmt_ctrl_model u_odtmt_ctrl_model (.hclk(hclk), .hresetn(hresetn),
    .odt_req(odt_req), .cke_req(cke_req), .wr_req(wr_req),
    .chop_req(chop_req), .ref_req(ref_req), .pins(pins));

  initial
  begin
    forever #25 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr();
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1]
      ^ lfsr_reg[0]};
    return lfsr_reg;
  endfunction
  // edges counted from the sampling edge up to the visible change
  function automatic int exp_lat(input int wl);
    return wl - LAT_OFFSET + 1;
  endfunction
  function automatic int exp_wid(input logic chop);
    return chop ? CHOP_EXTRA : FULL_EXTRA;
  endfunction
  task automatic complete_run();
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  // bounded wait for one term bit, counting edges
  task automatic wait_bit(input int idx, input logic v, output int n);
    n = 0;
    do
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    while (term[idx] !== v && n < 40);
  endtask
  task automatic set_odt(input logic v, input int exp);
    int n;
    @(posedge hclk);
    odt_req <= v;
    @(posedge hclk);
    #1;
    wait_bit(4, v, n);
    chk(32'(n), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    complete_run();
  end
  initial
  begin
    logic [31:0] rd;
    int wl;
    int n;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CFG_OFFSET, 32'h0, rd);
    chk(rd, 32'(WL_RESET));
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wl = WL_MIN + int'(lfsr() % 8);
      bus(1'b1, CFG_OFFSET, 32'(wl), rd);
      set_odt(1'b1, exp_lat(wl));
      set_odt(1'b0, exp_lat(wl));
    end
    // select codes 0..3 with full and chopped bursts, then fixed chop
    for (int i = 0; i < 9; i++)
    begin
      rd = (i == 8) ? 32'h125 : (32'h205 | (32'(i % 4) << CFG_RTT_WR_LSB));
      bus(1'b1, CFG_OFFSET, rd, rd);
      @(posedge hclk);
      wr_req <= 1'b1;
      chop_req <= (i < 8) && i[2];
      @(posedge hclk);
      wr_req <= 1'b0;
      #1;
      wait_bit(3, 1'b1, n);
      if (i % 4 == 0 && i != 8)
        chk(32'(n), 32'h28);
      else
      begin
        chk(32'(n), 32'(exp_lat(WL_RESET)));
        wait_bit(3, 1'b0, n);
        chk(32'(n), 32'(exp_wid(i == 8 || i[2])));
      end
      repeat (8) @(posedge hclk);
    end
    // pass 0 plain entry, 1 refresh pending, 2 dll kept running
    bus(1'b1, CFG_OFFSET, 32'(WL_RESET), rd);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        bus(1'b1, CFG_OFFSET, 32'h85, rd);
      @(posedge hclk);
      ref_req <= (k == 1);
      @(posedge hclk);
      ref_req <= 1'b0;
      cke_req <= 1'b0; // odt held still while windows are open
      @(posedge hclk);
      #1;
      wait_bit(0, 1'b1, n);
      chk(32'(n), 32'h1);
      chk(32'(term.window), 32'(k != 2));
      wait_bit(1, 1'b0, n);
      if (k == 1)
        chk(32'(n > 1 && n < 5), 32'h1);
      else
        chk(32'(n), 32'h1);
      chk(32'(term.async_mode), 32'(k != 2));
      bus(1'b0, STATUS_OFFSET, 32'h0, rd);
      chk(rd, (32'h1 << ST_PD_BIT) | (32'(k != 2) << ST_ASYNC_BIT));
      set_odt(1'b1, (k != 2) ? 1 : exp_lat(WL_RESET));
      repeat (4) @(posedge hclk);
      set_odt(1'b0, (k != 2) ? 1 : exp_lat(WL_RESET));
      @(posedge hclk);
      cke_req <= 1'b1;
      @(posedge hclk);
      #1;
      wait_bit(0, 1'b0, n);
      chk(32'(term.window), 32'(k != 2));
      wait_bit(1, 1'b0, n);
      chk(32'(n), (k != 2) ? 32'(EXIT_CYC) : 32'h1);
      chk(32'(term.async_mode), 32'h0);
    end
    bus(1'b1, 8'h08, lfsr(), rd);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, CFG_OFFSET, 32'h0, rd);
    chk(rd, 32'h85);
    complete_run();
  end
endmodule // odt_mode_transition_logic_tb
`default_nettype wire
